/* hdl/sdp_pkg.sv */
package sdp_pkg;

   // ************************************************************
   // Widths and sizes
   // ************************************************************
   localparam int BEAT_BYTES = 64;
   localparam int EMPTY_W = 6;
   localparam int DATA_W = 512;
   localparam int ADDR_W = 49;
   localparam int LEN_W = 31;
   localparam int BEATS_W = 25;
   localparam int HOST_BIT = 48;
   localparam int FIFO_DEPTH = 16;
   localparam int DESC_DEPTH = 4;
   localparam int WR_OUTST_W = 8;

   // ************************************************************
   // Constants and reset values
   // ************************************************************
   localparam logic [30:0] LEN_MAX = 31'h4000_0000;
   localparam logic [6:0] BEAT_BYTES_V = 7'h40;
   localparam logic [ADDR_W-1:0] BEAT_STEP = 49'h0_0000_0000_0040;
   localparam logic [23:0] REG_WINDOW = 24'h000100;
   localparam logic [23:0] FEAT_NEXT_OFS = REG_WINDOW;
   localparam logic [3:0] FEAT_TYPE = 4'h2;
   localparam logic [WR_OUTST_W-1:0] WR_OUTST_RST = 8'h00;

   // Beats needed for a byte length, rounded up to whole beats
   function automatic logic [BEATS_W-1:0] beats_of(input logic [LEN_W-1:0] len);
      logic [LEN_W:0] sum;
      sum = {1'b0, len} + 32'h0000_003f;
      return sum[BEATS_W+5:6];
   endfunction

   // Top address bit picks host memory over local memory
   function automatic logic is_host(input logic [ADDR_W-1:0] addr);
      return addr[HOST_BIT];
   endfunction

endpackage

/* hdl/sdp_fifo.sv */
`timescale 1ns/1ps
module sdp_fifo
   import sdp_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16,
   parameter int CW = $clog2(DEPTH + 1)
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o,
   output logic [CW-1:0] count_o
);
   // Depth must be a power of two so the pointers wrap by themselves
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] wp_nxt;
   logic [AW-1:0] rp_r;
   logic [AW-1:0] rp_nxt;
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic push;
   logic pop;

   assign in_ready_o = (cnt_r != CW'(DEPTH));
   assign out_valid_o = (cnt_r != '0);
   assign out_data_o = mem[rp_r];
   assign count_o = cnt_r;
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   always_comb
   begin
      wp_nxt = push ? AW'(wp_r + 1'b1) : wp_r;
      rp_nxt = pop ? AW'(rp_r + 1'b1) : rp_r;
      cnt_nxt = cnt_r + CW'(push) - CW'(pop);
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end
      else
      begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem[wp_r] <= in_data_i;
      end
   end

   chk_fifo_bound: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      cnt_r <= CW'(DEPTH)) else $error("fifo count above depth");
endmodule

/* hdl/sdp_wr_track.sv */
`timescale 1ns/1ps
module sdp_wr_track
   import sdp_pkg::*;
#(
   parameter int CNT_W = WR_OUTST_W
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic issue_i,
   input wire logic ack_i,
   output logic idle_o,
   output logic [CNT_W-1:0] count_o
);
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;

   // ************************************************************
   // Outstanding write count
   // ************************************************************
   // writes issued less acknowledgements returned
   always_comb
   begin
      cnt_nxt = cnt_r + CNT_W'(issue_i) - CNT_W'(ack_i);
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt_r <= WR_OUTST_RST;
      end
      else
      begin
         cnt_r <= cnt_nxt;
      end
   end

   assign idle_o = (cnt_r == '0);
   assign count_o = cnt_r;

   chk_ack_owed: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ack_i |-> (cnt_r != '0)) else $error("write ack with nothing outstanding");
endmodule

/* hdl/sdp_dma_top.sv */
`timescale 1ns/1ps
// Contract
// - Read engine fetches a buffer and streams it out in order.
// - One descriptor covers up to one gigabyte without splitting.
// - Beats carry 64 bytes; only the final beat may be partial.
// - Packet mode: last beat carries the count of unused lanes.
// - Packet mode: first beat flagged first, last beat flagged last.
// - Write engine stores received beats in order into the buffer.
// - Packet mode: whole payload between first and last markers stored; code ends at the descriptor length if that comes first.
// - Write engine reports the byte count written per transfer.
// - On request, completion waits until all writes are acknowledged.
// - Descriptors queue and go one at a time to the master.
// - Read master issues reads and turns returned data into beats.
// - Feature header is 64 bits, next pointer 0x100.
// - All engine ports fit in a 0x100 byte window.
// - Register traffic on receive channel 0 is split off, never ordered.
// - Read data returns in issue order.
// - Local address path reaches 256 terabytes.
// - Write acknowledgements are passed back to the write master.
// - 49-bit address; upper half host memory, lower half local.
module sdp_dma_top
   import sdp_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH,
   parameter logic [11:0] FEATURE_ID = 12'h001 // Arbitrary value
)
(
   input wire logic CORE_CLK_I,
   input wire logic RESETN_I,
   output logic [63:0] FEAT_HDR_O,
   input wire logic M2S_DESC_VALID_I,
   output logic M2S_DESC_READY_O,
   input wire logic [ADDR_W-1:0] M2S_DESC_ADDR_I,
   input wire logic [LEN_W-1:0] M2S_DESC_LEN_I,
   input wire logic M2S_DESC_PKT_I,
   output logic RD_REQ_O,
   input wire logic RD_REQ_READY_I,
   output logic [ADDR_W-1:0] RD_ADDR_O,
   output logic RD_HOST_O,
   input wire logic RX0_VALID_I,
   input wire logic RX0_MMIO_I,
   input wire logic [DATA_W-1:0] RX0_DATA_I,
   output logic RD_DATA_READY_O,
   output logic MMIO_REQ_O,
   output logic M2S_VALID_O,
   input wire logic M2S_READY_I,
   output logic [DATA_W-1:0] M2S_DATA_O,
   output logic M2S_SOP_O,
   output logic M2S_EOP_O,
   output logic [EMPTY_W-1:0] M2S_EMPTY_O,
   output logic M2S_DONE_O,
   input wire logic S2M_DESC_VALID_I,
   output logic S2M_DESC_READY_O,
   input wire logic [ADDR_W-1:0] S2M_DESC_ADDR_I,
   input wire logic [LEN_W-1:0] S2M_DESC_LEN_I,
   input wire logic S2M_DESC_PKT_I,
   input wire logic S2M_DESC_WAIT_I,
   input wire logic S2M_VALID_I,
   output logic S2M_READY_O,
   input wire logic [DATA_W-1:0] S2M_DATA_I,
   input wire logic S2M_SOP_I,
   input wire logic S2M_EOP_I,
   input wire logic [EMPTY_W-1:0] S2M_EMPTY_I,
   output logic WR_REQ_O,
   input wire logic WR_REQ_READY_I,
   output logic [ADDR_W-1:0] WR_ADDR_O,
   output logic WR_HOST_O,
   output logic [DATA_W-1:0] WR_DATA_O,
   output logic [BEAT_BYTES-1:0] WR_BYTEEN_O,
   input wire logic WR_ACK_I,
   output logic [LEN_W-1:0] RSP_BYTES_O,
   output logic RSP_VALID_O,
   output logic S2M_DONE_O
);
   localparam int CW = $clog2(DEPTH + 1);
   localparam int MDW = ADDR_W + LEN_W + 1;
   localparam int SDW = ADDR_W + LEN_W + 2;

   // ************************************************************
   // Feature header
   // ************************************************************
   // next pointer field
   assign FEAT_HDR_O = {FEAT_TYPE, 20'h00000, FEAT_NEXT_OFS, 4'h0, FEATURE_ID};

   // ************************************************************
   // Receive channel 0 split
   // ************************************************************
   logic rd_ret;
   assign rd_ret = RX0_VALID_I & ~RX0_MMIO_I;
   assign MMIO_REQ_O = RX0_VALID_I & RX0_MMIO_I;

   // ************************************************************
   // Read engine
   // ************************************************************
   logic md_valid;
   logic md_take;
   logic [MDW-1:0] md_word;
   logic [ADDR_W-1:0] md_addr;
   logic [LEN_W-1:0] md_len;
   logic md_pkt;
   logic df_in_ready;
   logic df_valid;
   logic [CW-1:0] df_count;
   logic m_busy_r, m_busy_nxt;
   logic m_first_r, m_first_nxt;
   logic m_pkt_r, m_pkt_nxt;
   logic m_done_r, m_done_nxt;
   logic [ADDR_W-1:0] m_addr_r, m_addr_nxt;
   logic [LEN_W-1:0] m_len_r, m_len_nxt;
   logic [BEATS_W-1:0] m_rd_left_r, m_rd_left_nxt;
   logic [BEATS_W-1:0] m_out_left_r, m_out_left_nxt;
   logic [CW-1:0] m_outst_r, m_outst_nxt;
   logic rd_fire;
   logic m_pop;

   sdp_fifo #(.WIDTH(MDW), .DEPTH(DESC_DEPTH)) u_m2s_desc (
      .clk_i(CORE_CLK_I),
      .rst_n_i(RESETN_I),
      .in_valid_i(M2S_DESC_VALID_I),
      .in_ready_o(M2S_DESC_READY_O),
      .in_data_i({M2S_DESC_ADDR_I, M2S_DESC_LEN_I, M2S_DESC_PKT_I}),
      .out_valid_o(md_valid),
      .out_ready_i(md_take),
      .out_data_o(md_word),
      .count_o()
   );
   assign {md_addr, md_len, md_pkt} = md_word;

   sdp_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_m2s_data (
      .clk_i(CORE_CLK_I),
      .rst_n_i(RESETN_I),
      .in_valid_i(rd_ret),
      .in_ready_o(df_in_ready),
      .in_data_i(RX0_DATA_I),
      .out_valid_o(df_valid),
      .out_ready_i(M2S_READY_I),
      .out_data_o(M2S_DATA_O),
      .count_o(df_count)
   );
   assign RD_DATA_READY_O = df_in_ready;

   // issue only with room for every reply
   assign RD_REQ_O = m_busy_r && (m_rd_left_r != '0) &&
                     (({1'b0, m_outst_r} + {1'b0, df_count}) < (CW + 1)'(DEPTH));
   assign RD_ADDR_O = m_addr_r;
   assign RD_HOST_O = is_host(m_addr_r);
   assign rd_fire = RD_REQ_O & RD_REQ_READY_I;
   assign m_pop = df_valid & M2S_READY_I;

   assign M2S_VALID_O = df_valid;
   assign M2S_SOP_O = m_pkt_r & m_first_r & df_valid;
   assign M2S_EOP_O = m_pkt_r & (m_out_left_r == BEATS_W'(1)) & df_valid;
   // unused lanes on the last beat
   assign M2S_EMPTY_O = M2S_EOP_O ? EMPTY_W'(6'h00 - m_len_r[5:0]) : '0;
   assign M2S_DONE_O = m_done_r;

   always_comb
   begin
      m_busy_nxt = m_busy_r;
      m_first_nxt = m_first_r;
      m_pkt_nxt = m_pkt_r;
      m_addr_nxt = m_addr_r;
      m_len_nxt = m_len_r;
      m_rd_left_nxt = m_rd_left_r;
      m_out_left_nxt = m_out_left_r;
      m_done_nxt = 1'b0;
      md_take = 1'b0;
      m_outst_nxt = m_outst_r + CW'(rd_fire) - CW'(rd_ret);
      if (!m_busy_r && md_valid)
      begin
         md_take = 1'b1;
         if (md_len != '0)
         begin
            m_busy_nxt = 1'b1;
            m_first_nxt = 1'b1;
            m_pkt_nxt = md_pkt;
            m_addr_nxt = md_addr;
            m_len_nxt = md_len;
            m_rd_left_nxt = beats_of(md_len);
            m_out_left_nxt = beats_of(md_len);
         end
         else
         begin
            m_done_nxt = 1'b1;
         end
      end
      if (rd_fire)
      begin
         m_addr_nxt = m_addr_r + BEAT_STEP;
         m_rd_left_nxt = m_rd_left_r - BEATS_W'(1);
      end
      if (m_pop)
      begin
         m_first_nxt = 1'b0;
         m_out_left_nxt = m_out_left_r - BEATS_W'(1);
         if (m_out_left_r == BEATS_W'(1))
         begin
            m_busy_nxt = 1'b0;
            m_done_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         m_busy_r <= 1'b0;
         m_first_r <= 1'b0;
         m_pkt_r <= 1'b0;
         m_done_r <= 1'b0;
         m_addr_r <= '0;
         m_len_r <= '0;
         m_rd_left_r <= '0;
         m_out_left_r <= '0;
         m_outst_r <= '0;
      end
      else
      begin
         m_busy_r <= m_busy_nxt;
         m_first_r <= m_first_nxt;
         m_pkt_r <= m_pkt_nxt;
         m_done_r <= m_done_nxt;
         m_addr_r <= m_addr_nxt;
         m_len_r <= m_len_nxt;
         m_rd_left_r <= m_rd_left_nxt;
         m_out_left_r <= m_out_left_nxt;
         m_outst_r <= m_outst_nxt;
      end
   end

   // ************************************************************
   // Write engine
   // ************************************************************
   logic sd_valid;
   logic sd_take;
   logic [SDW-1:0] sd_word;
   logic [ADDR_W-1:0] sd_addr;
   logic [LEN_W-1:0] sd_len;
   logic sd_pkt;
   logic sd_wait;
   logic s_busy_r, s_busy_nxt;
   logic s_drain_r, s_drain_nxt;
   logic s_pkt_r, s_pkt_nxt;
   logic s_wait_r, s_wait_nxt;
   logic s_done_r, s_done_nxt;
   logic [ADDR_W-1:0] s_addr_r, s_addr_nxt;
   logic [BEATS_W-1:0] s_left_r, s_left_nxt;
   logic [LEN_W-1:0] s_bytes_r, s_bytes_nxt;
   logic [LEN_W-1:0] rsp_bytes_r, rsp_bytes_nxt;
   logic rsp_valid_r, rsp_valid_nxt;
   logic wr_valid_r, wr_valid_nxt;
   logic [ADDR_W-1:0] wr_addr_r, wr_addr_nxt;
   logic [DATA_W-1:0] wr_data_r, wr_data_nxt;
   logic [BEAT_BYTES-1:0] wr_be_r, wr_be_nxt;
   logic s_accept;
   logic s_pkt_end;
   logic [6:0] s_beat_bytes;
   logic trk_idle;

   sdp_fifo #(.WIDTH(SDW), .DEPTH(DESC_DEPTH)) u_s2m_desc (
      .clk_i(CORE_CLK_I),
      .rst_n_i(RESETN_I),
      .in_valid_i(S2M_DESC_VALID_I),
      .in_ready_o(S2M_DESC_READY_O),
      .in_data_i({S2M_DESC_ADDR_I, S2M_DESC_LEN_I, S2M_DESC_PKT_I, S2M_DESC_WAIT_I}),
      .out_valid_o(sd_valid),
      .out_ready_i(sd_take),
      .out_data_o(sd_word),
      .count_o()
   );
   assign {sd_addr, sd_len, sd_pkt, sd_wait} = sd_word;

   sdp_wr_track u_wr_track (
      .clk_i(CORE_CLK_I),
      .rst_n_i(RESETN_I),
      .issue_i(wr_valid_r & WR_REQ_READY_I),
      .ack_i(WR_ACK_I),
      .idle_o(trk_idle),
      .count_o()
   );

   // stall without descriptor or write room
   assign S2M_READY_O = s_busy_r & ~s_drain_r & (~wr_valid_r | WR_REQ_READY_I);
   assign s_accept = S2M_VALID_I & S2M_READY_O;
   assign s_pkt_end = s_pkt_r & S2M_EOP_I;
   // partial lanes on last beat only
   assign s_beat_bytes = s_pkt_end ? 7'(BEAT_BYTES_V - {1'b0, S2M_EMPTY_I}) : BEAT_BYTES_V;

   assign WR_REQ_O = wr_valid_r;
   assign WR_ADDR_O = wr_addr_r;
   assign WR_HOST_O = is_host(wr_addr_r);
   assign WR_DATA_O = wr_data_r;
   assign WR_BYTEEN_O = wr_be_r;
   assign RSP_BYTES_O = rsp_bytes_r;
   assign RSP_VALID_O = rsp_valid_r;
   assign S2M_DONE_O = s_done_r;

   always_comb
   begin
      s_busy_nxt = s_busy_r;
      s_drain_nxt = s_drain_r;
      s_pkt_nxt = s_pkt_r;
      s_wait_nxt = s_wait_r;
      s_addr_nxt = s_addr_r;
      s_left_nxt = s_left_r;
      s_bytes_nxt = s_bytes_r;
      rsp_bytes_nxt = rsp_bytes_r;
      rsp_valid_nxt = rsp_valid_r;
      wr_valid_nxt = wr_valid_r & ~WR_REQ_READY_I;
      wr_addr_nxt = wr_addr_r;
      wr_data_nxt = wr_data_r;
      wr_be_nxt = wr_be_r;
      s_done_nxt = 1'b0;
      sd_take = 1'b0;
      if (!s_busy_r && sd_valid)
      begin
         sd_take = 1'b1;
         rsp_valid_nxt = 1'b0;
         if (sd_len != '0)
         begin
            s_busy_nxt = 1'b1;
            s_pkt_nxt = sd_pkt;
            s_wait_nxt = sd_wait;
            s_addr_nxt = sd_addr;
            s_left_nxt = beats_of(sd_len);
            s_bytes_nxt = '0;
         end
         else
         begin
            s_done_nxt = 1'b1;
            rsp_bytes_nxt = '0;
            rsp_valid_nxt = 1'b1;
         end
      end
      // payload runs to its last marker or to the descriptor length, whichever comes first
      if (s_accept)
      begin
         wr_valid_nxt = 1'b1;
         wr_addr_nxt = s_addr_r;
         wr_data_nxt = S2M_DATA_I;
         wr_be_nxt = {BEAT_BYTES{1'b1}} >> (s_pkt_end ? S2M_EMPTY_I : 6'h00);
         s_addr_nxt = s_addr_r + BEAT_STEP;
         s_left_nxt = s_left_r - BEATS_W'(1);
         s_bytes_nxt = s_bytes_r + LEN_W'(s_beat_bytes);
         if (s_pkt_end || s_left_r == BEATS_W'(1))
         begin
            s_drain_nxt = 1'b1;
         end
      end
      if (s_drain_r && !wr_valid_r && (!s_wait_r || trk_idle))
      begin
         s_busy_nxt = 1'b0;
         s_drain_nxt = 1'b0;
         s_done_nxt = 1'b1;
         rsp_bytes_nxt = s_bytes_r;
         rsp_valid_nxt = 1'b1;
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         s_busy_r <= 1'b0;
         s_drain_r <= 1'b0;
         s_pkt_r <= 1'b0;
         s_wait_r <= 1'b0;
         s_done_r <= 1'b0;
         s_addr_r <= '0;
         s_left_r <= '0;
         s_bytes_r <= '0;
         rsp_bytes_r <= '0;
         rsp_valid_r <= 1'b0;
         wr_valid_r <= 1'b0;
         wr_addr_r <= '0;
         wr_data_r <= '0;
         wr_be_r <= '0;
      end
      else
      begin
         s_busy_r <= s_busy_nxt;
         s_drain_r <= s_drain_nxt;
         s_pkt_r <= s_pkt_nxt;
         s_wait_r <= s_wait_nxt;
         s_done_r <= s_done_nxt;
         s_addr_r <= s_addr_nxt;
         s_left_r <= s_left_nxt;
         s_bytes_r <= s_bytes_nxt;
         rsp_bytes_r <= rsp_bytes_nxt;
         rsp_valid_r <= rsp_valid_nxt;
         wr_valid_r <= wr_valid_nxt;
         wr_addr_r <= wr_addr_nxt;
         wr_data_r <= wr_data_nxt;
         wr_be_r <= wr_be_nxt;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RESETN_I);

   chk_empty_last: assert property (
      M2S_EOP_O |-> M2S_EMPTY_O == EMPTY_W'(6'h00 - m_len_r[5:0]))
      else $error("empty count wrong on last beat");
   chk_full_mid: assert property (
      M2S_VALID_O && !M2S_EOP_O |-> M2S_EMPTY_O == '0)
      else $error("partial beat before the last");
   chk_nopkt_quiet: assert property (
      M2S_VALID_O && !m_pkt_r |-> !M2S_SOP_O && !M2S_EOP_O && M2S_EMPTY_O == '0)
      else $error("packet flags outside packet mode");
   chk_last_ends: assert property (
      m_pop && M2S_EOP_O |=> !m_busy_r && M2S_DONE_O)
      else $error("transfer did not end on last beat");
   chk_read_room: assert property (
      ({1'b0, m_outst_r} + {1'b0, df_count}) <= (CW + 1)'(DEPTH))
      else $error("reads outstanding exceed buffer room");
   chk_sink_stall: assert property (
      !s_busy_r || s_drain_r |-> !S2M_READY_O)
      else $error("sink ready with no active descriptor");
   chk_irq_after_acks: assert property (
      S2M_DONE_O && $past(s_drain_r) && $past(s_wait_r) |-> $past(trk_idle))
      else $error("completion before writes acknowledged");
   chk_rsp_bytes: assert property (
      S2M_DONE_O && $past(s_drain_r) |-> RSP_BYTES_O == $past(s_bytes_r) && RSP_VALID_O)
      else $error("response count mismatch");
   chk_mmio_split: assert property (
      RX0_VALID_I && RX0_MMIO_I |-> MMIO_REQ_O && !rd_ret)
      else $error("register traffic reached read data");

   cov_m2s_packet: cover property (m_pop && M2S_EOP_O && M2S_EMPTY_O != '0);
   cov_s2m_wait: cover property (S2M_DONE_O && $past(s_wait_r));
   cov_data_full: cover property (!df_in_ready);
   cov_sink_stall: cover property (S2M_VALID_I && s_busy_r && !S2M_READY_O);
endmodule

/* tb/sdp_mem_model.sv */
`timescale 1ns/1ps
module sdp_mem_model
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic slow_i,
   input wire logic rd_req_i,
   input wire logic [48:0] rd_addr_i,
   output logic rd_ready_o,
   output logic rx_valid_o,
   output logic [511:0] rx_data_o,
   input wire logic wr_req_i,
   output logic wr_ready_o,
   output logic ack_o
);
   logic [48:0] rq[$];
   int due[$];
   int t;
   logic rd_hit;
   logic wr_hit;
   logic [48:0] rd_a;
   // Sampled mid-cycle so design flops never race the model
   always @(negedge clk_i)
   begin
      rd_hit = rd_req_i && rd_ready_o;
      wr_hit = wr_req_i && wr_ready_o;
      rd_a = rd_addr_i;
   end
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rq.delete();
         due.delete();
         t = 0;
         rx_valid_o <= 1'b0;
         rx_data_o <= '0;
         ack_o <= 1'b0;
         rd_ready_o <= 1'b0;
         wr_ready_o <= 1'b0;
      end
      else
      begin
         t = t + 1;
         if (rd_hit)
            rq.push_back(rd_a);
         rx_valid_o <= 1'b0;
         rx_data_o <= ~rx_data_o;
         if (rq.size() > 0 && !(slow_i && t[1]))
         begin
            rx_valid_o <= 1'b1;
            rx_data_o <= {8{15'h0000, rq.pop_front()}};
         end
         // one late ack per accepted write
         if (wr_hit)
            due.push_back(t + (slow_i ? 20 : 1));
         ack_o <= 1'b0;
         if (due.size() > 0 && due[0] <= t)
         begin
            ack_o <= 1'b1;
            void'(due.pop_front());
         end
         rd_ready_o <= !(slow_i && t[0]);
         wr_ready_o <= !(slow_i && t[0]);
      end
   end
endmodule

/* tb/sdp_dma_top_tb.sv */
`timescale 1ns/1ps
module sdp_dma_top_tb;
   import sdp_pkg::*;
   typedef struct {logic [30:0] len; logic pkt; logic stall;} sdp_row_s;
   logic CORE_CLK_I, RESETN_I, M2S_DESC_VALID_I, M2S_DESC_READY_O, M2S_DESC_PKT_I, RD_REQ_O;
   logic RD_REQ_READY_I, RD_HOST_O, RX0_VALID_I, RX0_MMIO_I, RD_DATA_READY_O, MMIO_REQ_O;
   logic M2S_VALID_O, M2S_READY_I, M2S_SOP_O, M2S_EOP_O, M2S_DONE_O, S2M_DESC_VALID_I;
   logic S2M_DESC_READY_O, S2M_DESC_PKT_I, S2M_DESC_WAIT_I, S2M_VALID_I, S2M_READY_O;
   logic S2M_SOP_I, S2M_EOP_I, WR_REQ_O, WR_REQ_READY_I, WR_HOST_O, WR_ACK_I, RSP_VALID_O;
   logic S2M_DONE_O, mem_v, mmio_v, slow, rhost;
   logic [63:0] FEAT_HDR_O, WR_BYTEEN_O, last_be;
   logic [ADDR_W-1:0] M2S_DESC_ADDR_I, RD_ADDR_O, S2M_DESC_ADDR_I, WR_ADDR_O, wbase;
   logic [LEN_W-1:0] M2S_DESC_LEN_I, S2M_DESC_LEN_I, RSP_BYTES_O;
   logic [DATA_W-1:0] RX0_DATA_I, M2S_DATA_O, S2M_DATA_I, WR_DATA_O;
   logic [EMPTY_W-1:0] M2S_EMPTY_O, S2M_EMPTY_I;
   int err_total, total_checks, cyc, wcnt, outst, wnb;
   // aligned bases, partial lengths packet only
   sdp_row_s rows[4] = '{'{31'h1004, 1, 1}, '{31'h40, 0, 0}, '{31'h1, 1, 0}, '{31'h430, 1, 1}};
   sdp_dma_top DUT (.*);
   sdp_mem_model mem (.clk_i(CORE_CLK_I), .rst_n_i(RESETN_I), .slow_i(slow), .rd_req_i(RD_REQ_O),
      .rd_addr_i(RD_ADDR_O), .rd_ready_o(RD_REQ_READY_I), .rx_valid_o(mem_v),
      .rx_data_o(RX0_DATA_I), .wr_req_i(WR_REQ_O), .wr_ready_o(WR_REQ_READY_I), .ack_o(WR_ACK_I));
   assign RX0_VALID_I = mem_v | mmio_v;
   assign RX0_MMIO_I = mmio_v;
   initial
   begin
      CORE_CLK_I = 0;
      forever #2.5 CORE_CLK_I = ~CORE_CLK_I;
   end
   function automatic logic [511:0] pat(input logic [48:0] a);
      return {8{15'h0000, a}};
   endfunction
   task automatic check(input logic [511:0] seen, input logic [511:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      if (err_total == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge CORE_CLK_I)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         err_total++;
         conclude;
      end
   end
   // ****************
   // Write-side and read-side monitor
   // ****************
   always @(negedge CORE_CLK_I)
   begin
      if (WR_REQ_O === 1'b1 && WR_REQ_READY_I === 1'b1)
      begin
         check(WR_ADDR_O, wbase + 49'(64 * wcnt));
         check(WR_DATA_O, pat(49'(wcnt)));
         check(WR_BYTEEN_O, (wcnt == wnb - 1) ? last_be : {64{1'b1}});
         check(WR_HOST_O, wbase[48]);
         wcnt++;
         outst++;
      end
      if (RD_REQ_O === 1'b1)
         check(RD_HOST_O, rhost);
      if (mem_v === 1'b1)
         check(RD_DATA_READY_O, 1);
      if (WR_ACK_I === 1'b1)
         outst--;
   end
   task automatic run_read(input int r);
      int n, i, k;
      logic [48:0] a;
      a = {r[0], 48'h0000_0001_0000};
      rhost = r[0];
      n = (rows[r].len + 63) / 64;
      slow = rows[r].stall;
      @(posedge CORE_CLK_I); #1;
      // descriptors on ports, no control access
      M2S_DESC_VALID_I = 1;
      M2S_DESC_ADDR_I = a;
      M2S_DESC_LEN_I = rows[r].len;
      M2S_DESC_PKT_I = rows[r].pkt;
      check(M2S_DESC_READY_O, 1);
      @(posedge CORE_CLK_I); #1;
      M2S_DESC_VALID_I = 0;
      i = 0;
      k = 0;
      while (i < n && k < 3000)
      begin
         M2S_READY_I = rows[r].stall ? ~M2S_READY_I : 1'b1;
         #3;
         k++;
         if (M2S_VALID_O === 1'b1 && M2S_READY_I === 1'b1)
         begin
            check(M2S_DATA_O, pat(a + 49'(64 * i)));
            check(M2S_SOP_O, rows[r].pkt && i == 0);
            check(M2S_EOP_O, rows[r].pkt && i == n - 1);
            check(M2S_EMPTY_O, (rows[r].pkt && i == n - 1) ? (64 - rows[r].len % 64) % 64 : 0);
            i++;
         end
         if (i < n)
            @(posedge CORE_CLK_I) #1;
      end
      M2S_READY_I = 1;
      k = 0;
      while (M2S_DONE_O !== 1'b1 && k < 50)
      begin
         #5;
         k++;
      end
      check(k < 3, 1);
   endtask
   task automatic run_write(input logic [30:0] len, input logic pkt, input logic hold, input int nb,
      input logic [5:0] emp, input logic [30:0] exp);
      int i, k;
      wcnt = 0;
      wnb = nb;
      last_be = {64{1'b1}} >> (pkt ? emp : 6'h00);
      wbase = 49'h1_0000_0020_0000;
      slow = hold;
      @(posedge CORE_CLK_I); #1;
      S2M_DESC_VALID_I = 1;
      S2M_DESC_ADDR_I = wbase;
      S2M_DESC_LEN_I = len;
      S2M_DESC_PKT_I = pkt;
      S2M_DESC_WAIT_I = hold;
      check(S2M_DESC_READY_O, 1);
      @(posedge CORE_CLK_I); #1;
      S2M_DESC_VALID_I = 0;
      for (i = 0; i < nb; i++)
      begin
         S2M_VALID_I = 1;
         S2M_DATA_I = pat(49'(i));
         S2M_SOP_I = i == 0;
         S2M_EOP_I = pkt && i == nb - 1;
         S2M_EMPTY_I = S2M_EOP_I ? emp : 6'h00;
         k = 0;
         #3;
         while (S2M_READY_O !== 1'b1 && k < 500)
         begin
            #5;
            k++;
         end
         @(posedge CORE_CLK_I); #1;
      end
      S2M_VALID_I = 0;
      S2M_DATA_I = ~S2M_DATA_I;
      k = 0;
      #3;
      while (S2M_DONE_O !== 1'b1 && k < 500)
      begin
         #5;
         k++;
      end
      check(RSP_BYTES_O, exp);
      check(RSP_VALID_O, 1);
      check(wcnt, nb);
      if (hold)
         check(outst, 0);
   endtask
   initial
   begin
      {M2S_DESC_VALID_I, M2S_DESC_PKT_I, S2M_DESC_VALID_I, S2M_DESC_PKT_I, S2M_DESC_WAIT_I} = 0;
      {S2M_VALID_I, S2M_SOP_I, S2M_EOP_I, mmio_v, slow, RESETN_I} = 0;
      {M2S_DESC_ADDR_I, M2S_DESC_LEN_I, S2M_DESC_ADDR_I, S2M_DESC_LEN_I, S2M_EMPTY_I} = 0;
      S2M_DATA_I = '0;
      M2S_READY_I = 1;
      wbase = '0;
      repeat (20) @(posedge CORE_CLK_I);
      check(M2S_VALID_O, 0);
      check(S2M_READY_O, 0);
      #1 RESETN_I = 1;
      check(FEAT_HDR_O[39:16], 24'h000100);
      for (int r = 0; r < 4; r++)
         run_read(r);
      @(posedge CORE_CLK_I); #1;
      mmio_v = 1;
      #3 check(MMIO_REQ_O, 1);
      @(posedge CORE_CLK_I); #1;
      mmio_v = 0;
      #3 check(M2S_VALID_O, 0);
      check(S2M_READY_O, 0);
      run_write(31'h3e8, 1, 1, 3, 6'h0a, 31'h0b6);
      run_write(31'h80, 0, 0, 2, 6'h00, 31'h080);
      @(posedge CORE_CLK_I); #1;
      RESETN_I = 0;
      #3 check(RSP_VALID_O, 0);
      check(S2M_DESC_READY_O, 1);
      @(posedge CORE_CLK_I); #1;
      RESETN_I = 1;
      #3 check(S2M_READY_O, 0);
      conclude;
   end
endmodule
